// >>> inc/tsp_map.svh
// register offsets, reset values and field positions for the timer/serial port block
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH
`define TSP_OFF_P4_DIR 16'hffb5
`define TSP_OFF_P4_LAT 16'hffb7
`define TSP_OFF_P5_DIR 16'hffb8
`define TSP_OFF_P5_LAT 16'hffba
`define TSP_P4_RST 8'h00
`define TSP_P5_RST 8'hf8
`define TSP_P5_RSVD 8'hf8
`define TSP_DIR_READ 8'hff
`define TSP_ADDR_W 16
`define TSP_PIN_PWM1 7
`define TSP_PIN_PWM0 6
`define TSP_PIN_HREQ12 5
`define TSP_PIN_TMO1 4
`define TSP_PIN_HREQ11 3
`define TSP_PIN_TMRI0 2
`define TSP_PIN_TMO0 1
`define TSP_PIN_TMCI0 0
`define TSP_P5_SCK 2
`define TSP_P5_RXD 1
`define TSP_P5_TXD 0
`endif

// >>> inc/tsp_pkg.sv
// types for the timer/serial port block
package tsp_pkg;
    typedef enum logic [2:0] {
        TSP_IDLE = 3'b001,
        TSP_RESP = 3'b010,
        TSP_STBY = 3'b100
    } tsp_state_e;
    typedef struct packed {
        tsp_state_e state;
        logic [7:0] p4_dir;
        logic [7:0] p4_lat;
        logic [2:0] p5_dir;
        logic [2:0] p5_lat;
        logic [7:0] rdata;
        logic waitreq;
        logic [7:0] p4_out;
        logic [7:0] p4_oe_n;
        logic [2:0] p5_out;
        logic [2:0] p5_oe_n;
        logic [1:0] tmr_reset_in;
        logic [1:0] tmr_clock_in;
        logic sci_clk_in;
        logic sci_rxd_in;
    } tsp_state_s;
endpackage

// >>> hdl/tsp_port.sv
// port 4 and port 5 pin multiplexer with direction and output latches
//
// Contract
// [R1] port4 has eight pins, port5 three, port5 same in every mode
// [R2] general use: direction 1 drives latch, direction 0 is input
// [R3] direction registers are write-only and read back all ones
// [R4] reset and hardware standby clear port4 registers; software standby keeps them
// [R5] reset and hardware standby load port5 registers with f8; software standby keeps
// [R6] pins with direction 1 keep driving through software standby
// [R7] in software standby peripherals drop out, pins fall back to general use
// [R8] data read gives latch where direction 1, pin level where 0
// [R9] port5 data bits 7..3 ignore writes and read as one
// [R10] pins 7 and 6 carry pwm output when its enable is set
// [R11] slave mode, direction 1: pins 5,4,3 output host requests 12,1,11
// [R12] pins 4 and 1 carry timer compare output when output select nonzero
// [R13] pins 5 and 2 feed timer counter reset when both clear bits set
// [R14] pins 3 and 0 feed timer clock input when external clock selected
// [R15] serial clock pin: enable1 input, else sync or enable0 output, else io
// [R16] receive pin serves receive data when receiver enabled
// [R17] transmit pin drives transmit data when transmitter enabled
// [R18] slave mode is active when host interface enable is set
// [R19] peripheral controls are inputs combined every clock with registers
`timescale 1ns/100ps
`include "tsp_map.svh"
module tsp_port
    import tsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic host_interface_enable,
    input wire logic [1:0] pwm_oe,
    input wire logic [1:0] pwm_output,
    input wire logic host_int_req_12,
    input wire logic host_int_req_11,
    input wire logic host_int_req_1,
    input wire logic [3:0] timer0_output_select,
    input wire logic [3:0] timer1_output_select,
    input wire logic [1:0] timer_compare_output,
    input wire logic [1:0] timer0_counter_clear_select,
    input wire logic [1:0] timer1_counter_clear_select,
    input wire logic [1:0] timer_clock_external,
    input wire logic clock_enable_0,
    input wire logic clock_enable_1,
    input wire logic sync_mode,
    input wire logic receiver_enable,
    input wire logic transmitter_enable,
    input wire logic serial_clock_out,
    input wire logic serial_txd_out,
    input wire logic [7:0] p4_pin_in,
    output logic [7:0] p4_pin_out,
    output logic [7:0] p4_pin_oe_n,
    input wire logic [2:0] p5_pin_in,
    output logic [2:0] p5_pin_out,
    output logic [2:0] p5_pin_oe_n,
    output logic [1:0] timer_reset_input,
    output logic [1:0] timer_clock_input,
    output logic serial_clock_in,
    output logic serial_rxd_in
);
    // ==================================================
    // helpers
    function automatic logic [7:0] tsp_read_mux(input logic [7:0] dir, input logic [7:0] lat,
                                                input logic [7:0] pin);
        tsp_read_mux = (dir & lat) | (~dir & pin); // [R8]
    endfunction

    tsp_state_s st_reg;
    tsp_state_s st_next;
    logic slave_mode;
    logic periph_on;
    logic [7:0] p4_gp_oe;
    logic [7:0] p4_mux_oe;
    logic [7:0] p4_mux_out;
    logic [2:0] p5_mux_oe;
    logic [2:0] p5_mux_out;
    logic [7:0] p5_dir_w;
    logic [7:0] p5_lat_w;
    logic [7:0] p5_pin_w;

    // ==================================================
    // pin function selection
    always_comb begin
        slave_mode = host_interface_enable && !sw_standby; // [R18] [R7]
        periph_on = !sw_standby; // [R7]
        p4_gp_oe = st_reg.p4_dir; // [R2] [R6]
        p4_mux_oe = p4_gp_oe;
        p4_mux_out = st_reg.p4_lat;
        // host interrupt requests on pins 5,4,3
        if (slave_mode && st_reg.p4_dir[`TSP_PIN_HREQ12]) begin
            p4_mux_out[`TSP_PIN_HREQ12] = host_int_req_12; // [R11]
        end
        if (slave_mode && st_reg.p4_dir[`TSP_PIN_TMO1]) begin
            p4_mux_out[`TSP_PIN_TMO1] = host_int_req_1; // [R11]
        end
        if (slave_mode && st_reg.p4_dir[`TSP_PIN_HREQ11]) begin
            p4_mux_out[`TSP_PIN_HREQ11] = host_int_req_11; // [R11]
        end
        // timer compare outputs override direction and slave mode
        if (periph_on && (timer1_output_select != 4'h0)) begin
            p4_mux_oe[`TSP_PIN_TMO1] = 1'b1; // [R12]
            p4_mux_out[`TSP_PIN_TMO1] = timer_compare_output[1];
        end
        if (periph_on && (timer0_output_select != 4'h0)) begin
            p4_mux_oe[`TSP_PIN_TMO0] = 1'b1; // [R12]
            p4_mux_out[`TSP_PIN_TMO0] = timer_compare_output[0];
        end
        // pwm outputs override direction
        if (periph_on && pwm_oe[1]) begin
            p4_mux_oe[`TSP_PIN_PWM1] = 1'b1; // [R10]
            p4_mux_out[`TSP_PIN_PWM1] = pwm_output[1];
        end
        if (periph_on && pwm_oe[0]) begin
            p4_mux_oe[`TSP_PIN_PWM0] = 1'b1; // [R10]
            p4_mux_out[`TSP_PIN_PWM0] = pwm_output[0];
        end
        // serial channel pins, identical in every mode
        p5_mux_oe = st_reg.p5_dir; // [R1] [R2]
        p5_mux_out = st_reg.p5_lat;
        if (periph_on && clock_enable_1) begin
            p5_mux_oe[`TSP_P5_SCK] = 1'b0; // [R15]
        end else if (periph_on && (sync_mode || clock_enable_0)) begin
            p5_mux_oe[`TSP_P5_SCK] = 1'b1; // [R15]
            p5_mux_out[`TSP_P5_SCK] = serial_clock_out;
        end
        if (periph_on && receiver_enable) begin
            p5_mux_oe[`TSP_P5_RXD] = 1'b0; // [R16]
        end
        if (periph_on && transmitter_enable) begin
            p5_mux_oe[`TSP_P5_TXD] = 1'b1; // [R17]
            p5_mux_out[`TSP_P5_TXD] = serial_txd_out;
        end
        p5_dir_w = {5'h1f, st_reg.p5_dir};
        p5_lat_w = {5'h1f, st_reg.p5_lat};
        p5_pin_w = {5'h1f, p5_pin_in};
    end

    // ==================================================
    // register file, bus slave and next state
    always_comb begin
        st_next = st_reg;
        st_next.p4_out = p4_mux_out; // [R19]
        st_next.p4_oe_n = ~p4_mux_oe;
        st_next.p5_out = p5_mux_out;
        st_next.p5_oe_n = ~p5_mux_oe;
        st_next.tmr_reset_in[1] = p4_pin_in[`TSP_PIN_HREQ12]
            & (&timer1_counter_clear_select); // [R13]
        st_next.tmr_reset_in[0] = p4_pin_in[`TSP_PIN_TMRI0]
            & (&timer0_counter_clear_select); // [R13]
        st_next.tmr_clock_in[1] = p4_pin_in[`TSP_PIN_HREQ11] & timer_clock_external[1]; // [R14]
        st_next.tmr_clock_in[0] = p4_pin_in[`TSP_PIN_TMCI0] & timer_clock_external[0]; // [R14]
        st_next.sci_clk_in = p5_pin_in[`TSP_P5_SCK] & clock_enable_1; // [R15]
        st_next.sci_rxd_in = receiver_enable ? p5_pin_in[`TSP_P5_RXD] : 1'b1; // [R16]
        st_next.waitreq = 1'b1;
        case (st_reg.state)
            TSP_IDLE: begin
                if (sw_standby) begin
                    st_next.state = TSP_STBY; // [R6]
                end else if (avs_write) begin
                    st_next.waitreq = 1'b0;
                    st_next.state = TSP_RESP;
                    st_next.rdata = 8'h00;
                end else if (avs_read) begin
                    st_next.waitreq = 1'b0;
                    st_next.state = TSP_RESP;
                    case (avs_address)
                        `TSP_OFF_P4_DIR: st_next.rdata = `TSP_DIR_READ; // [R3]
                        `TSP_OFF_P5_DIR: st_next.rdata = `TSP_DIR_READ; // [R3]
                        `TSP_OFF_P4_LAT: st_next.rdata = tsp_read_mux(st_reg.p4_dir,
                            st_reg.p4_lat, p4_pin_in); // [R8]
                        `TSP_OFF_P5_LAT: st_next.rdata = tsp_read_mux(p5_dir_w, p5_lat_w,
                            p5_pin_w) | `TSP_P5_RSVD; // [R9]
                        default: st_next.rdata = 8'h00;
                    endcase
                end
            end
            TSP_RESP: begin
                st_next.state = TSP_IDLE;
                // write lands at the edge where waitrequest is seen low
                if (avs_write) begin
                    case (avs_address)
                        `TSP_OFF_P4_DIR: st_next.p4_dir = avs_writedata;
                        `TSP_OFF_P4_LAT: st_next.p4_lat = avs_writedata;
                        `TSP_OFF_P5_DIR: st_next.p5_dir = avs_writedata[2:0];
                        `TSP_OFF_P5_LAT: st_next.p5_lat = avs_writedata[2:0]; // [R9]
                        default: st_next.p4_lat = st_reg.p4_lat;
                    endcase
                end
            end
            TSP_STBY: begin
                if (!sw_standby) begin
                    st_next.state = TSP_IDLE;
                end
            end
            default: begin
                st_next.state = TSP_IDLE;
            end
        endcase
        if (hw_standby) begin
            st_next.p4_dir = `TSP_P4_RST; // [R4]
            st_next.p4_lat = `TSP_P4_RST;
            st_next.p5_dir = 3'(`TSP_P5_RST); // [R5]
            st_next.p5_lat = 3'(`TSP_P5_RST);
            st_next.p4_oe_n = 8'hff;
            st_next.p5_oe_n = 3'h7;
            st_next.state = TSP_STBY;
            st_next.waitreq = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg.state <= TSP_IDLE;
            st_reg.p4_dir <= `TSP_P4_RST; // [R4]
            st_reg.p4_lat <= `TSP_P4_RST;
            st_reg.p5_dir <= 3'(`TSP_P5_RST); // [R5]
            st_reg.p5_lat <= 3'(`TSP_P5_RST);
            st_reg.rdata <= 8'h00;
            st_reg.waitreq <= 1'b1;
            st_reg.p4_out <= 8'h00;
            st_reg.p4_oe_n <= 8'hff;
            st_reg.p5_out <= 3'h0;
            st_reg.p5_oe_n <= 3'h7;
            st_reg.tmr_reset_in <= 2'h0;
            st_reg.tmr_clock_in <= 2'h0;
            st_reg.sci_clk_in <= 1'b0;
            st_reg.sci_rxd_in <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==================================================
    // outputs
    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign p4_pin_out = st_reg.p4_out;
    assign p4_pin_oe_n = st_reg.p4_oe_n;
    assign p5_pin_out = st_reg.p5_out;
    assign p5_pin_oe_n = st_reg.p5_oe_n;
    assign timer_reset_input = st_reg.tmr_reset_in;
    assign timer_clock_input = st_reg.tmr_clock_in;
    assign serial_clock_in = st_reg.sci_clk_in;
    assign serial_rxd_in = st_reg.sci_rxd_in;
endmodule

// >>> tb/tsp_port_checker.sv
// assertion checker for the timer/serial port block
`timescale 1ns/100ps
module tsp_port_checker
    import tsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic [7:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] pwm_oe,
    input wire logic [1:0] pwm_output,
    input wire logic [3:0] timer1_output_select,
    input wire logic [1:0] timer_compare_output,
    input wire logic transmitter_enable,
    input wire logic receiver_enable,
    input wire logic clock_enable_1,
    input wire logic [7:0] p4_pin_out,
    input wire logic [7:0] p4_pin_oe_n,
    input wire logic [2:0] p5_pin_oe_n
);
    // ========
    // pin and bus properties
    wire run = !sw_standby && !hw_standby;
    wire ack = avs_read && !avs_waitrequest;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_pwm; pwm_oe[1] && run |=>
        !p4_pin_oe_n[7] && p4_pin_out[7] == $past(pwm_output[1]); endproperty
    a_pwm: assert property (p_pwm) else $error("pwm pin wrong");
    property p_tmo; (|timer1_output_select) && run |-> ##1
        !p4_pin_oe_n[4] && p4_pin_out[4] == $past(timer_compare_output[1]); endproperty
    a_tmo: assert property (p_tmo) else $error("compare pin wrong");
    property p_txd; transmitter_enable && run |=> !p5_pin_oe_n[0]; endproperty
    a_txd: assert property (p_txd) else $error("transmit pin not driven");
    property p_rxd; receiver_enable && run |=> p5_pin_oe_n[1]; endproperty
    a_rxd: assert property (p_rxd) else $error("receive pin driven");
    property p_sck; clock_enable_1 && run |=> p5_pin_oe_n[2]; endproperty
    a_sck: assert property (p_sck) else $error("clock pin driven");
    property p_hw; hw_standby |=> (&p4_pin_oe_n) && (&p5_pin_oe_n); endproperty
    a_hw: assert property (p_hw) else $error("pin driven in standby");
    property p_dir; ack && (avs_address == 16'hffb5 || avs_address == 16'hffb8)
        |-> avs_readdata == 8'hff; endproperty
    a_dir: assert property (p_dir) else $error("direction read not ff");
    property p_rsv; ack && avs_address == 16'hffba |-> avs_readdata[7:3] == 5'h1f; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not one");
    c_pwm: cover property (pwm_oe[1] && run);
    c_stby: cover property (sw_standby);
    c_rd: cover property (ack);
endmodule
bind tsp_port tsp_port_checker CHK (.*);

// >>> tb/tsp_pins_model.sv
// far-side pin model: outside drivers resolved against the block
`timescale 1ns/100ps
module tsp_pins_model
    import tsp_pkg::*;
(
    input wire logic [7:0] p4_pin_out,
    input wire logic [7:0] p4_pin_oe_n,
    input wire logic [2:0] p5_pin_out,
    input wire logic [2:0] p5_pin_oe_n,
    input wire logic [7:0] ext4,
    input wire logic [2:0] ext5,
    output logic [7:0] p4_pin_in,
    output logic [2:0] p5_pin_in
);
    // driven pins follow the block, others the outside level
    assign p4_pin_in = (p4_pin_out & ~p4_pin_oe_n) | (ext4 & p4_pin_oe_n);
    assign p5_pin_in = (p5_pin_out & ~p5_pin_oe_n) | (ext5 & p5_pin_oe_n);
endmodule

// >>> tb/tsp_port_tb.sv
// self-checking testbench for the timer/serial port block
`timescale 1ns/100ps
module tsp_port_tb
    import tsp_pkg::*;
;
    logic ref_clk, rst_n, hw_standby, sw_standby, avs_read, avs_write, avs_waitrequest;
    logic [15:0] avs_address;
    logic [7:0] avs_writedata, avs_readdata, p4_pin_in, p4_pin_out, p4_pin_oe_n, ext4, rd;
    logic [2:0] p5_pin_in, p5_pin_out, p5_pin_oe_n, ext5;
    logic [1:0] pwm_oe, pwm_output, timer_compare_output, timer0_counter_clear_select;
    logic [1:0] timer1_counter_clear_select, timer_clock_external;
    logic [1:0] timer_reset_input, timer_clock_input;
    logic [3:0] timer0_output_select, timer1_output_select;
    logic host_interface_enable, host_int_req_12, host_int_req_11, host_int_req_1;
    logic clock_enable_0, clock_enable_1, sync_mode, receiver_enable, transmitter_enable;
    logic serial_clock_out, serial_txd_out, serial_clock_in, serial_rxd_in;
    int err_total = 0;
    int tests_run = 0;
    tsp_port DUT (.*);
    tsp_pins_model PINS (.*);
    // ========
    // common tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task close_out;
        if (err_total == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~w;
        avs_write <= w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            close_out();
        end
    endtask
    task rdc(input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    task settle;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // ========
    // scenarios
    task t_reset;
        settle();
        chk(p4_pin_oe_n, 8'hff);
        chk({5'h1f, p5_pin_oe_n}, 8'hff);
        rdc(16'hffb5, 8'hff);
        rdc(16'hffb7, 8'h3c);
        rdc(16'hffba, 8'hfa);
    endtask
    task t_gpio;
        acc(1'b1, 16'hffb5, 8'h3f);
        acc(1'b1, 16'hffb7, 8'ha5);
        acc(1'b1, 16'hffb8, 8'h03);
        acc(1'b1, 16'hffba, 8'h05);
        settle();
        chk(p4_pin_oe_n, 8'hc0);
        chk({2'h0, p4_pin_out[5:0]}, 8'h25);
        chk({5'h0, p5_pin_oe_n}, 8'h04);
        rdc(16'hffb7, 8'h25);
        rdc(16'hffba, 8'hf9);
        rdc(16'hffb8, 8'hff);
        rdc(16'hffb6, 8'h00);
    endtask
    task t_periph;
        @(posedge ref_clk);
        {pwm_oe, pwm_output, timer1_output_select, timer_compare_output} <= 10'h35a;
        {host_interface_enable, host_int_req_12, host_int_req_11} <= 3'b101;
        {transmitter_enable, receiver_enable, clock_enable_1, serial_txd_out} <= 4'b1110;
        {timer1_counter_clear_select, timer_clock_external} <= 4'b1101;
        ext5 <= 3'b110;
        settle();
        chk(p4_pin_oe_n, 8'h00);
        chk(p4_pin_out, 8'h5d);
        chk({p5_pin_oe_n, p5_pin_out[0], serial_clock_in, serial_rxd_in,
             timer_reset_input[1], timer_clock_input[0]}, 8'hcd);
        rdc(16'hffb7, 8'h65);
        @(posedge ref_clk);
        {clock_enable_1, sync_mode, serial_clock_out} <= 3'b011;
        settle();
        chk({5'h0, p5_pin_oe_n[2], p5_pin_out[2], 1'b0}, 8'h02);
    endtask
    task t_standby;
        @(posedge ref_clk);
        sw_standby <= 1'b1;
        settle();
        chk(p4_pin_oe_n, 8'hc0);
        chk({2'h0, p4_pin_out[5:0]}, 8'h25);
        chk({5'h0, p5_pin_oe_n}, 8'h04);
        @(posedge ref_clk);
        sw_standby <= 1'b0;
        {pwm_oe, timer1_output_select, host_interface_enable, sync_mode} <= '0;
        {transmitter_enable, receiver_enable} <= '0;
        rdc(16'hffb7, 8'h25);
        rdc(16'hffba, 8'hfd);
        @(posedge ref_clk);
        hw_standby <= 1'b1;
        settle();
        chk(p4_pin_oe_n & {5'h1f, p5_pin_oe_n}, 8'hff);
        @(posedge ref_clk);
        hw_standby <= 1'b0;
        rdc(16'hffb7, 8'h3c);
        rdc(16'hffba, 8'hfe);
    endtask
    // ========
    // clock and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_n, hw_standby, sw_standby, avs_read, avs_write} = '0;
        {avs_address, avs_writedata, ext4, ext5} = {16'h0, 8'h0, 8'h3c, 3'b010};
        {pwm_oe, pwm_output, timer0_output_select, timer1_output_select} = '0;
        {timer_compare_output, timer0_counter_clear_select, timer1_counter_clear_select} = '0;
        {timer_clock_external, host_interface_enable, host_int_req_12, host_int_req_11} = '0;
        {host_int_req_1, clock_enable_0, clock_enable_1, sync_mode, receiver_enable} = '0;
        {transmitter_enable, serial_clock_out, serial_txd_out} = '0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_gpio();
        t_periph();
        t_standby();
        close_out();
    end
endmodule
